//--- verilog/dtb_arb_defines.svh
// Purpose: Constants for the bus arbiter
// Assumes: Active-low bus lines, four request levels
// Notes: Included by the arbiter top module only
`ifndef DTB_ARB_DEFINES_SVH
`define DTB_ARB_DEFINES_SVH
`define ARB_LEVELS 4
`define ARB_TOP_LEVEL 2'h3
`define ARB_MODE_PRI 2'h0
`define ARB_MODE_RRS 2'h1
`define ARB_MODE_SGL 2'h2
`define ARB_MODE_MIX 2'h3
`define ARB_TIMEOUT_NS 20000
`define ARB_CLK_NS 10
`define ARB_TIMEOUT_CYC (`ARB_TIMEOUT_NS / `ARB_CLK_NS)
`endif

//--- verilog/dtb_arb_pkg.sv
// Purpose: Types for the bus arbiter
// Assumes: Included defines header
// Notes: Mode encodings come from the header
package dtb_arb_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_GRANT = 2'h1,
        ST_BUSY = 2'h2
    } arb_state_t;
endpackage : dtb_arb_pkg

//--- verilog/sync2.sv
// Purpose: Two-flop synchroniser for a bus of levels
// Assumes: Input asynchronous to clock
// Notes: Resets to all ones (released lines)
`timescale 1ns/10ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '1;
            q <= '1;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sync2

//--- verilog/arb_pick.sv
// Purpose: Combinational priority picker over four levels
// Assumes: req is active high, top is the highest-priority level
// Notes: Scans downward from top with wrap
`timescale 1ns/10ps
module arb_pick (
    input wire logic [3:0] req,
    input wire logic [1:0] top,
    output logic found,
    output logic [1:0] level
);
    always_comb begin
        logic [1:0] idx;
        idx = 2'h0;
        found = 1'b0;
        level = 2'h0;
        for (int i = 0; i < 4; i++) begin
            idx = top - 2'(i);
            if (!found && req[idx]) begin
                found = 1'b1;
                level = idx;
            end
        end
    end
endmodule : arb_pick

//--- verilog/dtb_arbiter.sv
// Purpose: Slot-one arbiter for the shared data transfer bus
// Assumes: Single clock, active-low bus lines, pins asynchronous
// Notes: Mode is a static input; grants leave as active-low levels
`timescale 1ns/10ps
`include "dtb_arb_defines.svh"

// Functional notes
// - Fixed mode ranks level three highest
// - Rotating mode moves priority down after grant
// - Single mode answers level three only
// - Grant by pulling chosen chain line low
// - Fixed mode drives clear and four grants
// - Rotating mode drives four grants, clear optional
// - Single mode drives level three grant only
// - Mixed mode: level three top, rotate rest
// - At most one grant at any time
// - Grant outputs feed first board position
// - Grant only when busy high and request
// - Clear low while higher request pending (fixed), or any other level pending (rotating with clear_enable)
module dtb_arbiter
    import dtb_arb_pkg::*;
#(
    parameter int TIMEOUT_CYC = `ARB_TIMEOUT_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [1:0] arb_mode,
    input wire logic clear_enable,
    input wire logic [3:0] bus_request_n,
    input wire logic bus_busy_n,
    output logic [3:0] grant_n,
    output logic [3:0] grant_oe,
    output logic bus_clear_n,
    output logic bus_clear_oe,
    output logic timeout
);
    localparam logic [15:0] TO_LAST = 16'(TIMEOUT_CYC - 1);

    typedef struct packed {
        arb_state_t state;
        logic [1:0] top;
        logic [1:0] level;
        logic [3:0] grant_n;
        logic bus_clear_n;
        logic busy_low_seen;
        logic [15:0] count;
        logic timeout;
    } arb_regs_t;

    arb_regs_t st_r;
    arb_regs_t st_nxt;

    logic [3:0] req_sync_n;
    logic busy_sync_n;
    logic [3:0] req;
    logic [3:0] req_eff;
    logic [1:0] pick_top;
    logic found;
    logic [1:0] pick_level;
    logic [3:0] higher;

    // Active-low one-hot pattern for a level
    function automatic logic [3:0] level_low(input logic [1:0] lvl);
        level_low = ~(4'h1 << lvl);
    endfunction : level_low

    // Two flops before any logic reads the pins
    sync2 #(.WIDTH(4)) u_req_sync (
        .clock(clock),
        .reset_n(reset_n),
        .d(bus_request_n),
        .q(req_sync_n)
    );
    sync2 #(.WIDTH(1)) u_busy_sync (
        .clock(clock),
        .reset_n(reset_n),
        .d(bus_busy_n),
        .q(busy_sync_n)
    );

    assign req = ~req_sync_n;

    // Mode shaping of the candidate set
    always_comb begin
        req_eff = req;
        pick_top = `ARB_TOP_LEVEL;
        unique case (arb_mode)
            `ARB_MODE_PRI: begin
                pick_top = `ARB_TOP_LEVEL;
            end
            `ARB_MODE_RRS: begin
                pick_top = st_r.top;
            end
            `ARB_MODE_SGL: begin
                req_eff = {req[3], 3'h0};
            end
            `ARB_MODE_MIX: begin
                // Level three first, then rotate among 0..2
                if (!req[3]) begin
                    req_eff = {1'b0, req[2:0]};
                    pick_top = st_r.top;
                end
            end
        endcase
    end

    arb_pick u_pick (
        .req(req_eff),
        .top(pick_top),
        .found(found),
        .level(pick_level)
    );

    // Requests above the owner's level
    always_comb begin
        higher = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (2'(i) > st_r.level) begin
                higher[i] = req[i];
            end
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.timeout = 1'b0;
        unique case (st_r.state)
            ST_IDLE: begin
                st_nxt.bus_clear_n = 1'b1;
                if (busy_sync_n && found) begin
                    st_nxt.state = ST_GRANT;
                    st_nxt.level = pick_level;
                    // Only one line ever low
                    st_nxt.grant_n = level_low(pick_level);
                    st_nxt.busy_low_seen = 1'b0;
                    st_nxt.count = 16'h0000;
                    if (arb_mode == `ARB_MODE_MIX) begin
                        st_nxt.top = (pick_level == 2'h0 ||
                            pick_level == 2'h3) ? 2'h2 :
                            pick_level - 2'h1;
                    end else begin
                        st_nxt.top = pick_level - 2'h1;
                    end
                end
            end
            ST_GRANT: begin
                st_nxt.count = st_r.count + 16'h0001;
                if (!busy_sync_n) begin
                    // Requester took the bus; drop the grant
                    st_nxt.state = ST_BUSY;
                    st_nxt.busy_low_seen = 1'b1;
                    st_nxt.grant_n = 4'hF;
                end else if (st_r.count == TO_LAST) begin
                    // Nobody answered: withdraw
                    st_nxt.state = ST_IDLE;
                    st_nxt.grant_n = 4'hF;
                    st_nxt.timeout = 1'b1;
                end
            end
            ST_BUSY: begin
                // Bus clear while higher level waits (fixed; rotating with clear_enable: any other level waits; mixed, single: never)
                if (arb_mode == `ARB_MODE_PRI) begin
                    st_nxt.bus_clear_n = ~(|higher);
                end else if (arb_mode == `ARB_MODE_RRS &&
                    clear_enable) begin
                    st_nxt.bus_clear_n =
                        ~(|(req & level_low(st_r.level)));
                end else begin
                    st_nxt.bus_clear_n = 1'b1;
                end
                if (busy_sync_n) begin
                    // Rising edge of busy ends ownership
                    st_nxt.state = ST_IDLE;
                    st_nxt.bus_clear_n = 1'b1;
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
                st_nxt.grant_n = 4'hF;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{state: ST_IDLE, top: `ARB_TOP_LEVEL,
                level: 2'h0, grant_n: 4'hF, bus_clear_n: 1'b1,
                busy_low_seen: 1'b0, count: 16'h0000,
                timeout: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Slot-one outputs feed the first board position
    assign grant_n = st_r.grant_n;
    // Single mode leaves levels 0..2 undriven
    assign grant_oe = (arb_mode == `ARB_MODE_SGL) ? 4'h8 : 4'hF;
    assign bus_clear_n = st_r.bus_clear_n;
    assign bus_clear_oe = (arb_mode == `ARB_MODE_PRI) ||
        (arb_mode == `ARB_MODE_RRS && clear_enable);
    assign timeout = st_r.timeout;

    a_one_grant: assert property (
        @(posedge clock) disable iff (!reset_n)
        $countones(~grant_n) <= 1)
        else $error("more than one grant low");

    a_grant_busy_idle: assert property (
        @(posedge clock) disable iff (!reset_n)
        $rose(grant_n != 4'hF) |-> $past(busy_sync_n) && $past(found) &&
        $past(st_r.state == ST_IDLE))
        else $error("grant issued while bus busy or no request");

    a_grant_held: assert property (
        @(posedge clock) disable iff (!reset_n)
        (st_r.state == ST_GRANT && busy_sync_n &&
         st_r.count != TO_LAST) |=> $stable(grant_n))
        else $error("grant changed before handshake");

    a_no_regrant: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_BUSY && !busy_sync_n |=> grant_n == 4'hF)
        else $error("new grant while bus still busy");

    a_pri_order: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_IDLE && arb_mode == `ARB_MODE_PRI &&
        busy_sync_n && req[3] |=> grant_n == 4'h7)
        else $error("fixed mode did not favour level three");

    a_sgl_only3: assert property (
        @(posedge clock) disable iff (!reset_n)
        arb_mode == `ARB_MODE_SGL |-> grant_n[2:0] == 3'h7)
        else $error("single mode granted a low level");

    a_rr_rotate: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_IDLE && st_nxt.state == ST_GRANT &&
        arb_mode == `ARB_MODE_RRS |=> st_r.top == st_r.level - 2'h1)
        else $error("rotation pointer not moved below grant");

    a_clear_pri: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_BUSY && !busy_sync_n &&
        arb_mode == `ARB_MODE_PRI && |higher |=> !bus_clear_n)
        else $error("bus clear not asserted for higher request");

    a_clear_idle: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_IDLE |-> bus_clear_n)
        else $error("bus clear low while idle");

    a_clear_rrs: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_BUSY && !busy_sync_n &&
        arb_mode == `ARB_MODE_RRS && clear_enable &&
        |(req & level_low(st_r.level)) |=> !bus_clear_n)
        else $error("rotating clear not asserted for waiting level");

    a_sgl_grant_top: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_IDLE && arb_mode == `ARB_MODE_SGL &&
        busy_sync_n && req[3] |=> grant_n == 4'h7)
        else $error("single mode did not grant level three");

    a_mix_top: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_IDLE && arb_mode == `ARB_MODE_MIX &&
        busy_sync_n && req[3] |=> grant_n == 4'h7)
        else $error("mixed mode did not favour level three");

    a_grant_withdraw: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_GRANT && busy_sync_n &&
        st_r.count == TO_LAST |=> timeout && grant_n == 4'hF)
        else $error("unanswered grant not withdrawn");

    a_busy_seen: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_BUSY |-> st_r.busy_low_seen)
        else $error("busy state entered without busy low");

    a_grant_release: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_GRANT && !busy_sync_n |=>
        st_r.state == ST_BUSY && grant_n == 4'hF)
        else $error("grant not released after busy low");

    a_busy_rise: assert property (
        @(posedge clock) disable iff (!reset_n)
        st_r.state == ST_BUSY && busy_sync_n |=>
        st_r.state == ST_IDLE && bus_clear_n && grant_n == 4'hF)
        else $error("ownership not ended on busy rising edge");

    a_timeout_pulse: assert property (
        @(posedge clock) disable iff (!reset_n)
        timeout |=> !timeout)
        else $error("timeout pulse longer than one cycle");
endmodule : dtb_arbiter

//--- bench/dtb_requesters.sv
// Purpose: Board requesters sharing the four request levels
// Assumes: Open collector lines, idle high through pull-ups
// Notes: Requests queued by add, answered after lat cycles
`timescale 1ns/10ps
module dtb_requesters (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [3:0] add,
    input wire logic [3:0] grant_n,
    input int lat,
    input int hold,
    output logic [3:0] bus_request_n,
    output logic [3:0] grant_out_n,
    output logic bus_busy_n,
    output logic [1:0] won,
    output int won_n
);
    logic [3:0] pend;
    logic own;
    int cnt;
    assign bus_request_n = ~pend;
    // Requesting boards hold the grant, idle levels pass it on
    assign grant_out_n = grant_n | pend;
    always @(negedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pend = 4'h0;
            own = 1'b0;
            cnt = 0;
            bus_busy_n = 1'b1;
            won = 2'h0;
            won_n = 0;
        end else begin
            if (own) begin
                // Rising edge of busy frees the arbiter
                if (cnt >= hold) begin
                    own = 1'b0;
                    bus_busy_n = 1'b1;
                    cnt = 0;
                end else begin
                    cnt++;
                end
            end else if ((pend & ~grant_n) != 4'h0) begin
                // Grant is kept on board, not passed on
                if (cnt >= lat) begin
                    for (int i = 0; i < 4; i++) begin
                        if (pend[i] && !grant_n[i]) won = 2'(i);
                    end
                    pend[won] = 1'b0;
                    own = 1'b1;
                    bus_busy_n = 1'b0;
                    cnt = 0;
                    won_n++;
                end else begin
                    cnt++;
                end
            end else begin
                cnt = 0;
            end
            pend = pend | add;
        end
    end
endmodule : dtb_requesters

//--- bench/test_dtb_bus_arbitration.sv
// Purpose: Self-checking bench for the slot-one arbiter
// Assumes: Timeout shortened to 16 cycles
// Notes: Seeded random request sets plus corner cases
`timescale 1ns/10ps
module test_dtb_bus_arbitration;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] arb_mode = 2'h1;
    logic clear_enable = 1'b0;
    logic [3:0] add = 4'h0;
    int lat = 0;
    int hold = 2;
    logic [3:0] bus_request_n, grant_n, grant_oe, grant_out_n;
    logic bus_busy_n, bus_clear_n, bus_clear_oe, timeout;
    logic [1:0] won;
    logic [1:0] ptr = 2'h3;
    int won_n, n0;
    int miscompares = 0;
    int check_count = 0;
    always #5 clock = ~clock;
    dtb_arbiter #(.TIMEOUT_CYC(16)) dtb_arbiter_inst (.clock(clock),
        .reset_n(reset_n), .arb_mode(arb_mode),
        .clear_enable(clear_enable), .bus_request_n(bus_request_n),
        .bus_busy_n(bus_busy_n), .grant_n(grant_n), .grant_oe(grant_oe),
        .bus_clear_n(bus_clear_n), .bus_clear_oe(bus_clear_oe),
        .timeout(timeout));
    dtb_requesters dtb_requesters_inst (.clock(clock), .reset_n(reset_n),
        .add(add), .grant_n(grant_n), .lat(lat), .hold(hold),
        .bus_request_n(bus_request_n), .bus_busy_n(bus_busy_n),
        .won(won), .won_n(won_n), .grant_out_n(grant_out_n));
    task automatic check(input string what, input logic [3:0] seen,
                         input logic [3:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    function automatic logic [1:0] pick(input logic [3:0] p,
                                        input logic [1:0] top);
        logic [1:0] l;
        l = top;
        for (int i = 0; i < 4; i++) begin
            if (p[l]) return l;
            l = l - 2'h1;
        end
        return top;
    endfunction : pick
    task automatic wait_win();
        int c;
        c = won_n;
        for (int i = 0; i < 300 && won_n == c; i++) @(negedge clock);
        if (won_n == c) begin
            miscompares++;
            $display("MISMATCH grant expected win seen none");
            wrap_up();
        end
    endtask : wait_win
    task automatic drain(input logic [3:0] set, input bit rot);
        logic [3:0] p;
        logic [1:0] e;
        p = set;
        add <= set;
        @(negedge clock);
        add <= 4'h0;
        while (p != 4'h0) begin
            e = pick(p, rot ? ptr : 2'h3);
            wait_win();
            check("level", {2'h0, won}, {2'h0, e});
            p[e] = 1'b0;
            ptr = e - 2'h1;
        end
        repeat (12) @(negedge clock);
    endtask : drain
    // At most one grant line low at any time
    always @(negedge clock) begin
        if (reset_n) begin
            check("grants", ~grant_n & (~grant_n - 4'h1), 4'h0);
        end
    end
    // Boards with nothing pending pass every grant level on
    always @(posedge clock) begin
        if (reset_n && bus_request_n == 4'hF) begin
            check("chain", grant_out_n, grant_n);
        end
    end
    initial begin
        void'($urandom(32));
        repeat (8) @(negedge clock);
        check("reset", {grant_n[3:2], bus_clear_n, timeout}, 4'hE);
        reset_n <= 1'b1;
        drain(4'hF, 1'b1);
        drain(4'h5, 1'b1);
        repeat (4) drain(4'($urandom_range(15, 1)), 1'b1);
        check("rr oe", {grant_oe[2:0], bus_clear_oe}, 4'hE);
        clear_enable <= 1'b1;
        @(negedge clock);
        check("rr clr oe", {3'h0, bus_clear_oe}, 4'h1);
        drain(4'h6, 1'b1);
        $display("test rotating done");
        arb_mode <= 2'h0;
        repeat (2) @(negedge clock);
        check("pri oe", grant_oe, 4'hF);
        check("pri clr oe", {3'h0, bus_clear_oe}, 4'h1);
        repeat (6) begin
            lat = $urandom_range(3, 0);
            hold = $urandom_range(5, 1);
            drain(4'($urandom_range(15, 1)), 1'b0);
        end
        $display("test fixed done");
        arb_mode <= 2'h3;
        drain(4'h9, 1'b0);
        drain(4'hC, 1'b0);
        drain(4'h7, 1'b1);
        $display("test mixed done");
        arb_mode <= 2'h0;
        hold = 60;
        drain(4'h2, 1'b0);
        add <= 4'h8;
        repeat (8) @(negedge clock);
        add <= 4'h0;
        check("clear", {3'h0, bus_clear_n}, 4'h0);
        wait_win();
        check("preempt", {2'h0, won}, 4'h3);
        repeat (8) @(negedge clock);
        check("clear off", {3'h0, bus_clear_n}, 4'h1);
        repeat (70) @(negedge clock);
        $display("test clear done");
        hold = 2;
        lat = 40;
        add <= 4'h2;
        @(negedge clock);
        add <= 4'h0;
        for (int i = 0; i < 60 && timeout !== 1'b1; i++) @(negedge clock);
        check("timeout", {grant_n[3:1], timeout}, 4'hF);
        lat = 0;
        wait_win();
        check("retry", {2'h0, won}, 4'h1);
        repeat (12) @(negedge clock);
        $display("test timeout done");
        arb_mode <= 2'h2;
        repeat (2) @(negedge clock);
        check("sgl oe", grant_oe, 4'h8);
        drain(4'h8, 1'b0);
        n0 = won_n;
        add <= 4'h7;
        @(negedge clock);
        add <= 4'h0;
        repeat (40) @(negedge clock);
        check("sgl wins", 4'(won_n - n0), 4'h0);
        $display("test single done");
        wrap_up();
    end
endmodule : test_dtb_bus_arbitration
